// ---- bench/ber_peer.sv ----
// Far side of the BER tester: frame timing, connection word bits and a line loop.
// Assumes the tester's bit handshake; outputs come back on the inputs one frame later.
`timescale 1ns/1ps
module ber_peer #(
  parameter int FRAME = 10
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bit_ready,
  input wire logic [31:0] tx_bits,
  input wire logic [31:0] tx_drive_b,
  input wire logic [31:0] inv_mask,
  input wire logic [7:0] win_lo,
  input wire logic [7:0] win_len,
  output logic bit_valid,
  output logic [7:0] chan_index,
  output logic [31:0] rx_bits,
  output logic [95:0] cm_low_bits
);
  logic [31:0] line_q [FRAME*8];
  int pos_q;
  int last_q;
  logic took_q;
  logic in_win;

  // ==========================================================================
  // Frame position and connection words
  // The bench keeps the window off the last two channels, so it never wraps
  assign bit_valid = rst_b;
  assign chan_index = 8'(pos_q / 8);
  assign in_win = (chan_index >= win_lo) && (chan_index < win_lo + win_len);
  assign cm_low_bits = in_win ? {32{3'b101}} : '0;
  assign rx_bits = line_q[pos_q] ^ inv_mask;

  // ==========================================================================
  // Line loop
  // A refused bit is held; an undriven line shows the inverse of its last value
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_q <= 0;
      last_q <= 0;
      took_q <= 1'b0;
      for (int i = 0; i < FRAME*8; i++) begin
        line_q[i] <= '0;
      end
    end else begin
      took_q <= bit_valid && bit_ready;
      if (bit_valid && bit_ready) begin
        last_q <= pos_q;
        pos_q <= (pos_q == FRAME*8-1) ? 0 : pos_q + 1;
      end
      if (took_q) begin
        line_q[last_q] <= (tx_bits & ~tx_drive_b) | (~line_q[last_q] & tx_drive_b);
      end
    end
  end
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench of the BER tester: host accesses, looped pattern, error counts.
// Assumes ber_peer closes the stream loop; the host port needs no pull-ups.
`timescale 1ns/1ps
`include "ber_regs.svh"
module testbench
  import ber_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [13:0] upa_addr = '0;
  logic [15:0] upa_data_in = '0;
  logic upa_cs_b = 1'b1;
  logic upa_rd_b = 1'b1;
  logic upa_wr_b = 1'b1;
  logic [15:0] upa_data_out;
  logic upa_data_oe_b;
  logic upa_ready_b;
  logic bit_valid;
  logic bit_ready;
  logic [7:0] chan_index;
  logic [31:0] rx_bits;
  logic [95:0] cm_low_bits;
  logic [31:0] tx_bits;
  logic [31:0] tx_drive_b;
  logic [31:0] inv_mask = '0;
  logic [7:0] win_lo = 8'h00;
  logic [7:0] win_len = 8'h01;
  logic [15:0] rq;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;

  ber_tester #(.STREAMS(32), .FIFO_DEPTH(16)) u_dut (.clk(clk), .rst_b(rst_b),
    .upa_addr(upa_addr), .upa_data_in(upa_data_in), .upa_data_out(upa_data_out),
    .upa_data_oe_b(upa_data_oe_b), .upa_cs_b(upa_cs_b), .upa_rd_b(upa_rd_b),
    .upa_wr_b(upa_wr_b), .upa_ready_b(upa_ready_b), .bit_valid(bit_valid),
    .bit_ready(bit_ready), .chan_index(chan_index), .rx_bits(rx_bits),
    .cm_low_bits(cm_low_bits), .tx_bits(tx_bits), .tx_drive_b(tx_drive_b));

  ber_peer #(.FRAME(10)) u_peer (.clk(clk), .rst_b(rst_b), .bit_ready(bit_ready),
    .tx_bits(tx_bits), .tx_drive_b(tx_drive_b), .inv_mask(inv_mask), .win_lo(win_lo),
    .win_len(win_len), .bit_valid(bit_valid), .chan_index(chan_index),
    .rx_bits(rx_bits), .cm_low_bits(cm_low_bits));

  // ==========================================================================
  // Clock and hang guard
  always #2.5 clk = ~clk;

  // Ceiling sits well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      err_total++;
      close_out();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Pins held until ready is seen, released an edge later; cs_b high 3+ clocks after
  task automatic acc(input logic wr, input logic [13:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    upa_addr <= a;
    upa_data_in <= d;
    upa_cs_b <= 1'b0;
    upa_rd_b <= wr;
    upa_wr_b <= ~wr;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (upa_ready_b !== 1'b0 && n < 20);
    rq = upa_data_oe_b ? 16'hdead : upa_data_out;
    chk(upa_ready_b, 1'b0);
    @(posedge clk);
    upa_cs_b <= 1'b1;
    upa_rd_b <= 1'b1;
    upa_wr_b <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (upa_ready_b !== 1'b1 && n < 20);
    repeat (3) @(posedge clk);
  endtask

  task automatic rd(input logic [13:0] a);
    acc(1'b0, a, 16'h0000);
  endtask

  // Ends on an edge inside channel 9, which never carries the pattern
  task automatic wait_frame(input int k);
    repeat (k) begin
      do begin
        @(posedge clk);
        #1;
      end while (chan_index != 8'd8);
      do begin
        @(posedge clk);
        #1;
      end while (chan_index != 8'd9);
    end
    @(posedge clk);
  endtask

  // Every inverted in-window bit counts exactly one error, healing included
  function automatic err_count_t exp_cnt(input logic hit, input int len, input int frames);
    return hit ? err_count_t'(frames * 8 * len) : '0;
  endfunction

  // ==========================================================================
  // One window setting on all streams, then two frames of inverted input
  task automatic round(input int st, input int len, input logic [31:0] mask);
    logic [15:0] r;
    @(posedge clk);
    win_lo <= 8'(st);
    win_len <= 8'(len);
    for (int n = 0; n < 32; n++) begin
      r = 16'($urandom);
      acc(1'b1, {`BER_START_GROUP, 5'(n)}, {r[15:8], 8'(st)});
      rd({`BER_START_GROUP, 5'(n)});
      chk(rq, st);
      acc(1'b1, {`BER_LEN_GROUP, 5'(n)}, {r[15:9], 9'(len)});
      rd({`BER_LEN_GROUP, 5'(n)});
      chk(rq, len);
      acc(1'b1, {`BER_CTRL_GROUP, 5'(n)}, 16'h0001);
    end
    wait_frame(3);
    for (int n = 0; n < 32; n++) begin
      acc(1'b1, {`BER_CTRL_GROUP, 5'(n)}, 16'h0003);
    end
    wait_frame(3);
    for (int n = 0; n < 32; n++) begin
      rd({`BER_ERR_GROUP, 5'(n)});
      chk(rq, 16'h0000);
      rd({`BER_CTRL_GROUP, 5'(n)});
      chk(rq, 16'h0001);
    end
    // Line up on channel 9 first, so exactly two whole windows are inverted
    wait_frame(1);
    inv_mask <= mask;
    wait_frame(2);
    inv_mask <= '0;
    wait_frame(3);
    for (int n = 0; n < 32; n++) begin
      rd({`BER_ERR_GROUP, 5'(n)});
      chk(rq, exp_cnt(mask[n], len, 2));
    end
    $display("round start %0d length %0d done", st, len);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [15:0] m;
    int st;
    void'($urandom(53981));
    repeat (8) @(posedge clk);
    chk(tx_drive_b, 32'hffffffff);
    rst_b <= 1'b1;
    rd(`BER_IMS_ADDR);
    chk(rq, `BER_IMS_RST);
    rd({`BER_CTRL_GROUP, 5'd5});
    chk(rq, 16'h0000);
    rd({`BER_START_GROUP, 5'd5});
    chk(rq, `BER_START_RST);
    rd({`BER_LEN_GROUP, 5'd5});
    chk(rq, `BER_LEN_RST);
    rd({`BER_ERR_GROUP, 5'd5});
    chk(rq, 16'h0000);
    m = 16'($urandom);
    m[5:4] = 2'b11;
    acc(1'b1, `BER_IMS_ADDR, m);
    rd(`BER_IMS_ADDR);
    chk(rq, m);
    $display("reset values done");
    round(0, 8, $urandom);
    round(7, 1, $urandom);
    repeat (2) begin
      st = $urandom % 8;
      round(st, 1 + $urandom % (8 - st), $urandom);
    end
    // Receivers held off by the global enable count nothing
    for (int n = 0; n < 32; n++) begin
      acc(1'b1, {`BER_CTRL_GROUP, 5'(n)}, 16'h0003);
    end
    acc(1'b1, `BER_IMS_ADDR, 16'h0010);
    inv_mask <= '1;
    wait_frame(2);
    inv_mask <= '0;
    wait_frame(1);
    for (int n = 0; n < 32; n++) begin
      rd({`BER_ERR_GROUP, 5'(n)});
      chk(rq, 16'h0000);
    end
    // Count register ignores writes; unmapped places read zero
    acc(1'b1, {`BER_ERR_GROUP, 5'd3}, 16'h1234);
    rd({`BER_ERR_GROUP, 5'd3});
    chk(rq, 16'h0000);
    rd(14'h3fff);
    chk(rq, 16'h0000);
    acc(1'b1, `BER_IMS_ADDR, 16'h0000);
    #1;
    chk(tx_drive_b, 32'hffffffff);
    $display("enables and access kinds done");
    close_out();
  end
endmodule

// ---- common/ber_pkg.sv ----
// Types shared by the BER test logic.
// Assumes ber_regs.svh supplies the numeric constants.
package ber_pkg;

  // ========================================================================
  // Types
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACT = 2'b01,
    BUS_HOLD = 2'b10
  } bus_state_e;

  typedef logic [15:0] err_count_t;
  typedef logic [14:0] prbs_t;

  // Next bit of the 2^15-1 sequence, polynomial x^15 + x^14 + 1
  function automatic logic prbs_fb(input prbs_t s);
    prbs_fb = s[14] ^ s[13];
  endfunction

endpackage

// ---- common/ber_regs.svh ----
// Register offsets, field positions, reset values and counts of the BER test logic.
// Assumes a 14-bit word address on the parallel host port; included by bare name.
`ifndef BER_REGS_SVH
`define BER_REGS_SVH

// ==========================================================================
// Register map (word addresses; per-stream groups decoded on addr[13:5])
`define BER_IMS_ADDR 14'h0001
`define BER_CTRL_GROUP 9'h008
`define BER_START_GROUP 9'h00a
`define BER_LEN_GROUP 9'h00c
`define BER_ERR_GROUP 9'h00e

// ==========================================================================
// Field positions
`define BER_RX_ALL_EN_BIT 5
`define BER_TX_ALL_EN_BIT 4
`define BER_CLEAR_BIT 1
`define BER_START_BIT 0
`define BER_CM_MSG_BIT 0

// ==========================================================================
// Reset values and counts
`define BER_IMS_RST 16'h0000
`define BER_START_RST 8'h00
`define BER_LEN_RST 9'h001
`define BER_PRBS_SEED 15'h7fff
`define BER_CNT_MAX 16'hffff
`define BER_SYNC_BITS 4'hf
`define BER_PCC_BER 2'b10

`endif

// ---- hw/ber_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides and an almost-full flag.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/1ps
module ber_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic almost_full
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d, level;
  logic push, pop;

  // ========================================================================
  // Pointers; the extra pointer bit tells full from empty
  always_comb begin
    level = wr_q - rd_q;
    in_ready = (level != (AW+1)'(DEPTH));
    out_valid = (level != '0);
    almost_full = (level >= (AW+1)'(DEPTH - 1));
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    out_data = mem_q[rd_q[AW-1:0]];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Storage needs no reset; empty flag hides stale words
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule

// ---- hw/ber_rx_lane.sv ----
// One stream's pattern checker: channel window, local sequence, bit compare.
// Assumes step pulses once per received bit and chan_index is the current channel.
`timescale 1ns/1ps
`include "ber_regs.svh"
module ber_rx_lane
  import ber_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  input wire logic step,
  input wire logic rx_bit,
  input wire logic [7:0] chan_index,
  input wire logic [7:0] start_chan,
  input wire logic [8:0] length,
  output logic err
);
  prbs_t hist_q, hist_d;
  logic [3:0] sync_q, sync_d;
  logic [9:0] lo, hi;
  logic in_win;

  // ========================================================================
  // Self-synchronising checker: history of received bits predicts the next
  always_comb begin
    lo = {2'b00, chan_index};
    hi = {2'b00, start_chan} + {1'b0, length};
    in_win = (chan_index >= start_chan) && (lo < hi);
    hist_d = hist_q;
    sync_d = sync_q;
    if (!en) begin
      sync_d = '0;
    end else if (step && in_win) begin
      hist_d = {hist_q[13:0], rx_bit};
      if (sync_q != `BER_SYNC_BITS) begin
        sync_d = sync_q + 1'b1;
      end
    end
    // No error until fifteen bits have filled the history
    err = en & step & in_win & (sync_q == `BER_SYNC_BITS) & (rx_bit != prbs_fb(hist_q));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_q <= '0;
      sync_q <= '0;
    end else begin
      hist_q <= hist_d;
      sync_q <= sync_d;
    end
  end
endmodule

// ---- hw/ber_tester.sv ----
// Per-stream pseudorandom pattern transmitters, checkers and error counters.
// Assumes switch timing gives a bit strobe, channel index and connection word bits
// on clk; the host port pins are asynchronous and are synchronised here.
//
// How it works
// - One transmitter and receiver per stream, 32 each
// - Transmitters send the 2^15-1 sequence
// - Pattern may sit anywhere, one channel to frame
// - Global enables bits 5 and 4, off at reset
// - Control bit 1 clears count, bit 0 starts
// - Start register bits 7:0 pick first channel
// - Length register bits 8:0 hold channel count
// - Error counter saturates at ffff, read only
`timescale 1ns/1ps
`include "ber_regs.svh"
module ber_tester
  import ber_pkg::*;
#(
  parameter int STREAMS = 32,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [13:0] upa_addr,
  input wire logic [15:0] upa_data_in,
  output logic [15:0] upa_data_out,
  output logic upa_data_oe_b,
  input wire logic upa_cs_b,
  input wire logic upa_rd_b,
  input wire logic upa_wr_b,
  output logic upa_ready_b,
  input wire logic bit_valid,
  output logic bit_ready,
  input wire logic [7:0] chan_index,
  input wire logic [STREAMS-1:0] rx_bits,
  input wire logic [3*STREAMS-1:0] cm_low_bits,
  output logic [STREAMS-1:0] tx_bits,
  output logic [STREAMS-1:0] tx_drive_b
);
  localparam int LANES_PER_PASS = 8;
  localparam int PASSES = STREAMS / LANES_PER_PASS;

  // Saturating add of one bit; a full counter never wraps
  function automatic err_count_t sat_inc(input err_count_t c, input logic hit);
    sat_inc = (hit && c != `BER_CNT_MAX) ? c + 1'b1 : c;
  endfunction

  // ==========================================================================
  // Host port pin synchronisers
  logic [32:0] pin_s1_q, pin_s2_q;
  logic [13:0] p_addr;
  logic [15:0] p_data;
  logic p_cs_b, p_rd_b, p_wr_b;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= {19'h00000, 14'h0000} | 33'h000000007;
      pin_s2_q <= {19'h00000, 14'h0000} | 33'h000000007;
    end else begin
      pin_s1_q <= {upa_addr, upa_data_in, upa_cs_b, upa_rd_b, upa_wr_b};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign {p_addr, p_data, p_cs_b, p_rd_b, p_wr_b} = pin_s2_q;

  // ==========================================================================
  // Host port access sequencer and register file
  bus_state_e st_q, st_d;
  logic [15:0] dout_q, dout_d, ims_q, ims_d;
  logic oe_b_q, oe_b_d, rdy_b_q, rdy_b_d;
  logic [STREAMS-1:0] run_q, run_d, clr_pulse;
  logic [7:0] start_q [STREAMS];
  logic [7:0] start_d [STREAMS];
  logic [8:0] len_q [STREAMS];
  logic [8:0] len_d [STREAMS];
  err_count_t cnt_q [STREAMS];
  err_count_t cnt_d [STREAMS];
  logic wr_en, rd_en;
  logic [8:0] grp;
  logic [4:0] idx;

  // One access per chip-select assertion; the hold state waits for release
  always_comb begin
    st_d = st_q;
    dout_d = dout_q;
    oe_b_d = oe_b_q;
    rdy_b_d = rdy_b_q;
    ims_d = ims_q;
    run_d = run_q;
    start_d = start_q;
    len_d = len_q;
    clr_pulse = '0;
    grp = p_addr[13:5];
    idx = p_addr[4:0];
    wr_en = (st_q == BUS_ACT) && !p_wr_b;
    rd_en = (st_q == BUS_ACT) && !p_rd_b;
    case (st_q)
      BUS_IDLE: begin
        if (!p_cs_b && (!p_rd_b || !p_wr_b)) begin
          st_d = BUS_ACT;
        end
      end
      BUS_ACT: begin
        st_d = BUS_HOLD;
        rdy_b_d = 1'b0;
        oe_b_d = p_rd_b;
      end
      BUS_HOLD: begin
        if (p_cs_b) begin
          st_d = BUS_IDLE;
          rdy_b_d = 1'b1;
          oe_b_d = 1'b1;
        end
      end
      default: begin
        st_d = BUS_IDLE;
      end
    endcase
    if (wr_en) begin
      if (p_addr == `BER_IMS_ADDR) begin
        ims_d = p_data;
      end
      if (grp == `BER_CTRL_GROUP) begin
        run_d[idx] = p_data[`BER_START_BIT];
        clr_pulse[idx] = p_data[`BER_CLEAR_BIT];
      end
      if (grp == `BER_START_GROUP) begin
        start_d[idx] = p_data[7:0];
      end
      if (grp == `BER_LEN_GROUP) begin
        len_d[idx] = p_data[8:0];
      end
    end
    // Unmapped addresses read as zero; clear bit always reads back zero
    if (rd_en) begin
      dout_d = 16'h0000;
      if (p_addr == `BER_IMS_ADDR) begin
        dout_d = ims_q;
      end
      case (grp)
        `BER_CTRL_GROUP: dout_d = {15'h0000, run_q[idx]};
        `BER_START_GROUP: dout_d = {8'h00, start_q[idx]};
        `BER_LEN_GROUP: dout_d = {7'h00, len_q[idx]};
        `BER_ERR_GROUP: dout_d = cnt_q[idx];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= BUS_IDLE;
      dout_q <= 16'h0000;
      oe_b_q <= 1'b1;
      rdy_b_q <= 1'b1;
      ims_q <= `BER_IMS_RST;
      run_q <= '0;
      for (int n = 0; n < STREAMS; n++) begin
        start_q[n] <= `BER_START_RST;
        len_q[n] <= `BER_LEN_RST;
      end
    end else begin
      st_q <= st_d;
      dout_q <= dout_d;
      oe_b_q <= oe_b_d;
      rdy_b_q <= rdy_b_d;
      ims_q <= ims_d;
      run_q <= run_d;
      start_q <= start_d;
      len_q <= len_d;
    end
  end

  assign upa_data_out = dout_q;
  assign upa_data_oe_b = oe_b_q;
  assign upa_ready_b = rdy_b_q;

  // ==========================================================================
  // Receivers and error-word buffer
  logic rx_all_en, tx_all_en, step;
  logic [STREAMS-1:0] err_vec;
  logic push_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_afull;
  logic [STREAMS-1:0] fifo_out_data;
  logic bit_ready_q;

  assign rx_all_en = ims_q[`BER_RX_ALL_EN_BIT];
  assign tx_all_en = ims_q[`BER_TX_ALL_EN_BIT];
  assign step = bit_valid & bit_ready_q;

  for (genvar g = 0; g < STREAMS; g++) begin : g_lane
    // Each input stream owns its checker, paired by index with a transmitter
    ber_rx_lane u_lane (
      .clk(clk),
      .rst_b(rst_b),
      .en(rx_all_en & run_q[g]),
      .step(step),
      .rx_bit(rx_bits[g]),
      .chan_index(chan_index),
      .start_chan(start_q[g]),
      .length(len_q[g]),
      .err(err_vec[g])
    );
  end

  // Only words with at least one bad bit are buffered
  assign push_valid = step & (|err_vec);

  ber_fifo #(
    .WIDTH(STREAMS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(err_vec),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .almost_full(fifo_afull)
  );

  // Ready is registered, so it drops one word early to leave room for the late push
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_ready_q <= 1'b0;
    end else begin
      bit_ready_q <= ~fifo_afull;
    end
  end

  assign bit_ready = bit_ready_q;

  // ==========================================================================
  // Counter update: eight streams per pass, four passes per word
  logic [1:0] pass_q, pass_d;

  always_comb begin
    pass_d = pass_q;
    fifo_out_ready = fifo_out_valid && (pass_q == 2'(PASSES - 1));
    if (fifo_out_valid) begin
      pass_d = pass_q + 1'b1;
    end
    for (int n = 0; n < STREAMS; n++) begin
      // A clear in the same cycle as a hit leaves a count of one
      cnt_d[n] = sat_inc(clr_pulse[n] ? 16'h0000 : cnt_q[n],
        fifo_out_valid && fifo_out_data[n] && (n / LANES_PER_PASS == int'(pass_q)));
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pass_q <= 2'b00;
      for (int n = 0; n < STREAMS; n++) begin
        cnt_q[n] <= 16'h0000;
      end
    end else begin
      pass_q <= pass_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================================
  // Transmitters: each runs in channels whose connection word selects it
  prbs_t tx_lfsr_q [STREAMS];
  prbs_t tx_lfsr_d [STREAMS];
  logic [STREAMS-1:0] tx_bits_q, tx_bits_d, tx_drive_b_q, tx_drive_b_d, tx_act;

  always_comb begin
    tx_lfsr_d = tx_lfsr_q;
    tx_bits_d = tx_bits_q;
    tx_drive_b_d = tx_drive_b_q;
    for (int n = 0; n < STREAMS; n++) begin
      // Per-channel selection lets the pattern start and end anywhere in the frame
      tx_act[n] = tx_all_en && cm_low_bits[3*n + `BER_CM_MSG_BIT] &&
        (cm_low_bits[3*n+1 +: 2] == `BER_PCC_BER);
      if (!tx_all_en) begin
        tx_drive_b_d[n] = 1'b1;
      end else if (step) begin
        tx_drive_b_d[n] = ~tx_act[n];
        if (tx_act[n]) begin
          tx_bits_d[n] = prbs_fb(tx_lfsr_q[n]);
          tx_lfsr_d[n] = {tx_lfsr_q[n][13:0], prbs_fb(tx_lfsr_q[n])};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_bits_q <= '0;
      tx_drive_b_q <= '1;
      for (int n = 0; n < STREAMS; n++) begin
        tx_lfsr_q[n] <= `BER_PRBS_SEED;
      end
    end else begin
      tx_bits_q <= tx_bits_d;
      tx_drive_b_q <= tx_drive_b_d;
      tx_lfsr_q <= tx_lfsr_d;
    end
  end

  assign tx_bits = tx_bits_q;
  assign tx_drive_b = tx_drive_b_q;

  // ==========================================================================
  // Checks
  AST_SAT_HOLD:
  assert property (@(posedge clk) disable iff (!rst_b)
    (cnt_q[0] == 16'hffff && !clr_pulse[0]) |=> (cnt_q[0] == 16'hffff))
    else $error("Error counter left saturation without a clear");

  AST_CNT_STEP:
  assert property (@(posedge clk) disable iff (!rst_b)
    !clr_pulse[1] |=> (cnt_q[1] == $past(cnt_q[1]) || cnt_q[1] == $past(cnt_q[1]) + 16'h0001))
    else $error("Error counter moved by more than one");

  AST_CLEAR:
  assert property (@(posedge clk) disable iff (!rst_b)
    clr_pulse[2] |=> (cnt_q[2] <= 16'h0001))
    else $error("Clear did not reset the error counter");

  AST_RX_GATED:
  assert property (@(posedge clk) disable iff (!rst_b)
    (!rx_all_en || !run_q[3]) |-> !err_vec[3])
    else $error("Disabled receiver reported an error");

  AST_TX_OFF:
  assert property (@(posedge clk) disable iff (!rst_b)
    !tx_all_en |=> (tx_drive_b == '1))
    else $error("Transmitter drove while disabled");

  AST_PRBS_LIVE:
  assert property (@(posedge clk) disable iff (!rst_b)
    tx_lfsr_q[0] != 15'h0000)
    else $error("Pattern generator fell into the all-zero state");

  AST_TX_SEQ:
  assert property (@(posedge clk) disable iff (!rst_b)
    (step && tx_act[0]) |=> (tx_bits[0] == $past(tx_lfsr_q[0][14] ^ tx_lfsr_q[0][13]))
      && !tx_drive_b[0])
    else $error("Transmitted bit does not follow the sequence");

  AST_IMS_WRITE:
  assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == BUS_ACT && !p_wr_b && p_addr == 14'h0001) |=> (ims_q == $past(p_data)))
    else $error("Mode register write was not stored");

  AST_BUS_ACK:
  assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == BUS_IDLE && !p_cs_b && !p_rd_b) |-> ##2 !upa_ready_b)
    else $error("Host read not acknowledged in two cycles");

  AST_BACKPRESSURE:
  assert property (@(posedge clk) disable iff (!rst_b)
    push_valid |-> fifo_in_ready)
    else $error("Error word pushed into a full buffer");
endmodule
